// >>> common/alu_params.svh
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH

`define ALU_DATA_W 8
`define ALU_MSB 7
`define ALU_LSB 0
`define ACC_RST_VAL 8'h00
`define FLAG_RST_VAL 1'b0
`define FLAG_W 4
`define FLAG_Z_POS 0
`define FLAG_C_POS 1
`define FLAG_AC_POS 2
`define FLAG_OV_POS 3
`define RESULT_LATENCY 1

`endif

// >>> common/alu_ops_pkg.sv
package alu_ops_pkg;

   // operation selector presented with op_valid_i
   typedef enum logic [4:0] {
      OP_NOP,
      OP_LOAD_ACC_IMM,
      OP_LRS_ACC,
      OP_RRC_ACC,
      OP_LRS_MEM,
      OP_RRC_MEM,
      OP_LLS_ACC,
      OP_RLC_ACC,
      OP_LLS_MEM,
      OP_RLC_MEM,
      OP_SWAP_ACC,
      OP_AND_ACC_IMM,
      OP_AND_ACC_MEM,
      OP_AND_MEM_ACC,
      OP_OR_ACC_IMM,
      OP_OR_ACC_MEM,
      OP_OR_MEM_ACC,
      OP_XOR_ACC_IMM,
      OP_XOR_ACC_MEM,
      OP_XOR_MEM_ACC,
      OP_XOR_IO_ACC,
      OP_NOT_ACC,
      OP_NOT_MEM,
      OP_NEG_ACC
   } alu_op_t;

   typedef enum logic [1:0] {
      DST_NONE,
      DST_ACC,
      DST_MEM,
      DST_IO
   } alu_dest_t;

endpackage

// >>> rtl/byte_op_unit.sv
`include "alu_params.svh"

module byte_op_unit
   import alu_ops_pkg::*;
#(
   parameter int DATA_W = `ALU_DATA_W
) (
   input wire alu_op_t op_i,
   input wire logic [DATA_W-1:0] acc_i,
   input wire logic [DATA_W-1:0] mem_i,
   input wire logic [DATA_W-1:0] imm_i,
   input wire logic [DATA_W-1:0] io_i,
   input wire logic carry_i,
   output logic [DATA_W-1:0] res_o,
   output logic carry_o
);

   localparam int HALF = DATA_W / 2;

   // nibble swap needs two equal halves
   if (DATA_W < 2 || DATA_W % 2 != 0) begin : g_width_check
      $error("byte_op_unit: data width must be even and at least 2");
   end

   always_comb begin
      res_o = acc_i;
      carry_o = carry_i;
      case (op_i)
         OP_LOAD_ACC_IMM: res_o = imm_i;
         OP_LRS_ACC: begin
            res_o = {1'b0, acc_i[DATA_W-1:1]};
            carry_o = acc_i[0];
         end
         OP_RRC_ACC: begin
            res_o = {carry_i, acc_i[DATA_W-1:1]};
            carry_o = acc_i[0];
         end
         OP_LRS_MEM: begin
            res_o = {1'b0, mem_i[DATA_W-1:1]};
            carry_o = mem_i[0];
         end
         OP_RRC_MEM: begin
            res_o = {carry_i, mem_i[DATA_W-1:1]};
            carry_o = mem_i[0];
         end
         OP_LLS_ACC: begin
            res_o = {acc_i[DATA_W-2:0], 1'b0};
            carry_o = acc_i[DATA_W-1];
         end
         OP_RLC_ACC: begin
            res_o = {acc_i[DATA_W-2:0], carry_i};
            carry_o = acc_i[DATA_W-1];
         end
         OP_LLS_MEM: begin
            res_o = {mem_i[DATA_W-2:0], 1'b0};
            carry_o = mem_i[DATA_W-1];
         end
         OP_RLC_MEM: begin
            res_o = {mem_i[DATA_W-2:0], carry_i};
            carry_o = mem_i[DATA_W-1];
         end
         OP_SWAP_ACC: res_o = {acc_i[HALF-1:0], acc_i[DATA_W-1:HALF]};
         OP_AND_ACC_IMM: res_o = acc_i & imm_i;
         OP_AND_ACC_MEM,
         OP_AND_MEM_ACC: res_o = acc_i & mem_i;
         OP_OR_ACC_IMM: res_o = acc_i | imm_i;
         OP_OR_ACC_MEM,
         OP_OR_MEM_ACC: res_o = acc_i | mem_i;
         OP_XOR_ACC_IMM: res_o = acc_i ^ imm_i;
         OP_XOR_ACC_MEM,
         OP_XOR_MEM_ACC: res_o = acc_i ^ mem_i;
         OP_XOR_IO_ACC: res_o = acc_i ^ io_i;
         OP_NOT_ACC: res_o = ~acc_i;
         OP_NOT_MEM: res_o = ~mem_i;
         // negate modulo 2^DATA_W, carry out discarded on purpose
         OP_NEG_ACC: res_o = ~acc_i + {{(DATA_W-1){1'b0}}, 1'b1};
         default: begin
            res_o = acc_i;
            carry_o = carry_i;
         end
      endcase
   end

endmodule

// >>> rtl/shift_logic_alu_ops.sv
// Overview of operation
// - acc right shift: zero in, bit0 to carry
// - acc rotate right through carry
// - right shift/rotate also on memory byte
// - acc left shift: zero in, bit7 to carry
// - acc rotate left through carry
// - left shift/rotate also on memory byte
// - nibble swap, no flag changes
// - and with immediate, zero flag only
// - and with memory, either destination
// - or with immediate, zero flag only
// - or with memory, either destination
// - xor immediate or memory, either destination
// - xor into io register, flags untouched
// - invert accumulator, zero flag only
// - invert memory byte in place
// - negate accumulator, zero flag only
`include "alu_params.svh"

module shift_logic_alu_ops
   import alu_ops_pkg::*;
#(
   parameter int DATA_W = `ALU_DATA_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic op_valid_i,
   input wire alu_op_t op_i,
   input wire logic [DATA_W-1:0] imm_i,
   input wire logic [DATA_W-1:0] mem_rdata_i,
   input wire logic [DATA_W-1:0] io_rdata_i,
   input wire logic flag_we_i,
   input wire logic [`FLAG_W-1:0] flag_wdata_i,
   output logic [DATA_W-1:0] acc_o,
   output logic zero_flag_o,
   output logic carry_flag_o,
   output logic half_carry_flag_o,
   output logic signed_excess_flag_o,
   output logic mem_we_o,
   output logic [DATA_W-1:0] mem_wdata_o,
   output logic io_we_o,
   output logic [DATA_W-1:0] io_wdata_o,
   output logic done_o
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration check

   if (DATA_W != `ALU_DATA_W) begin : g_width_check
      $error("shift_logic_alu_ops: only 8-bit data is supported");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [DATA_W-1:0] acc_ff;
   logic zero_ff;
   logic carry_ff;
   logic half_carry_ff;
   logic signed_excess_ff;
   logic mem_we_ff;
   logic [DATA_W-1:0] mem_wdata_ff;
   logic io_we_ff;
   logic [DATA_W-1:0] io_wdata_ff;
   logic done_ff;

   logic [DATA_W-1:0] nxt_acc;
   logic nxt_zero;
   logic nxt_carry;
   logic nxt_half_carry;
   logic nxt_signed_excess;
   logic nxt_mem_we;
   logic [DATA_W-1:0] nxt_mem_wdata;
   logic nxt_io_we;
   logic [DATA_W-1:0] nxt_io_wdata;
   logic nxt_done;

   logic [DATA_W-1:0] op_res;
   logic op_carry;
   alu_dest_t dest;
   logic upd_zero;
   logic upd_carry;
   logic res_is_zero;

   ////////////////////////////////////////////////////////////////////////////
   // datapath

   byte_op_unit #(
      .DATA_W(DATA_W)
   ) u_byte_op (
      .op_i(op_i),
      .acc_i(acc_ff),
      .mem_i(mem_rdata_i),
      .imm_i(imm_i),
      .io_i(io_rdata_i),
      .carry_i(carry_ff),
      .res_o(op_res),
      .carry_o(op_carry)
   );

   assign res_is_zero = (op_res == '0);

   // destination and flag-update decode
   always_comb begin
      dest = DST_NONE;
      upd_zero = 1'b0;
      upd_carry = 1'b0;
      case (op_i)
         OP_LOAD_ACC_IMM: dest = DST_ACC;
         OP_LRS_ACC,
         OP_RRC_ACC,
         OP_LLS_ACC,
         OP_RLC_ACC: begin
            dest = DST_ACC;
            upd_carry = 1'b1;
         end
         OP_LRS_MEM,
         OP_RRC_MEM,
         OP_LLS_MEM,
         OP_RLC_MEM: begin
            dest = DST_MEM;
            upd_carry = 1'b1;
         end
         OP_SWAP_ACC: dest = DST_ACC;
         OP_AND_ACC_IMM,
         OP_AND_ACC_MEM,
         OP_OR_ACC_IMM,
         OP_OR_ACC_MEM,
         OP_XOR_ACC_IMM,
         OP_XOR_ACC_MEM,
         OP_NOT_ACC,
         OP_NEG_ACC: begin
            dest = DST_ACC;
            upd_zero = 1'b1;
         end
         OP_AND_MEM_ACC,
         OP_OR_MEM_ACC,
         OP_XOR_MEM_ACC,
         OP_NOT_MEM: begin
            dest = DST_MEM;
            upd_zero = 1'b1;
         end
         OP_XOR_IO_ACC: dest = DST_IO;
         default: begin
            dest = DST_NONE;
            upd_zero = 1'b0;
            upd_carry = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   // an executing operation owns the flags; a direct flag write that
   // lands in the same cycle is dropped so results stay consistent
   always_comb begin
      nxt_acc = acc_ff;
      nxt_zero = zero_ff;
      nxt_carry = carry_ff;
      nxt_half_carry = half_carry_ff;
      nxt_signed_excess = signed_excess_ff;
      nxt_mem_we = 1'b0;
      nxt_mem_wdata = mem_wdata_ff;
      nxt_io_we = 1'b0;
      nxt_io_wdata = io_wdata_ff;
      nxt_done = 1'b0;
      if (op_valid_i) begin
         nxt_done = 1'b1;
         case (dest)
            DST_ACC: nxt_acc = op_res;
            DST_MEM: begin
               nxt_mem_we = 1'b1;
               nxt_mem_wdata = op_res;
            end
            DST_IO: begin
               nxt_io_we = 1'b1;
               nxt_io_wdata = op_res;
            end
            default: nxt_acc = acc_ff;
         endcase
         if (upd_zero) begin
            nxt_zero = res_is_zero;
         end
         if (upd_carry) begin
            nxt_carry = op_carry;
         end
      end else if (flag_we_i) begin
         nxt_zero = flag_wdata_i[`FLAG_Z_POS];
         nxt_carry = flag_wdata_i[`FLAG_C_POS];
         nxt_half_carry = flag_wdata_i[`FLAG_AC_POS];
         nxt_signed_excess = flag_wdata_i[`FLAG_OV_POS];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         acc_ff <= `ACC_RST_VAL;
         zero_ff <= `FLAG_RST_VAL;
         carry_ff <= `FLAG_RST_VAL;
         half_carry_ff <= `FLAG_RST_VAL;
         signed_excess_ff <= `FLAG_RST_VAL;
         mem_we_ff <= 1'b0;
         mem_wdata_ff <= '0;
         io_we_ff <= 1'b0;
         io_wdata_ff <= '0;
         done_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         zero_ff <= nxt_zero;
         carry_ff <= nxt_carry;
         half_carry_ff <= nxt_half_carry;
         signed_excess_ff <= nxt_signed_excess;
         mem_we_ff <= nxt_mem_we;
         mem_wdata_ff <= nxt_mem_wdata;
         io_we_ff <= nxt_io_we;
         io_wdata_ff <= nxt_io_wdata;
         done_ff <= nxt_done;
      end
   end

   assign acc_o = acc_ff;
   assign zero_flag_o = zero_ff;
   assign carry_flag_o = carry_ff;
   assign half_carry_flag_o = half_carry_ff;
   assign signed_excess_flag_o = signed_excess_ff;
   assign mem_we_o = mem_we_ff;
   assign mem_wdata_o = mem_wdata_ff;
   assign io_we_o = io_we_ff;
   assign io_wdata_o = io_wdata_ff;
   assign done_o = done_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // helper: flag copies one edge old, held in flops so plain
   // continuous logic can compare against them
   logic prev_zero_ff;
   logic prev_carry_ff;
   logic prev_half_carry_ff;
   logic prev_signed_excess_ff;
   logic flags_hold_zc;
   logic flags_hold_all;

   always_ff @(posedge ref_clk_i) begin
      prev_zero_ff <= zero_ff;
      prev_carry_ff <= carry_ff;
      prev_half_carry_ff <= half_carry_ff;
      prev_signed_excess_ff <= signed_excess_ff;
   end

   // flags other than carry unchanged since the previous edge
   assign flags_hold_zc = (half_carry_ff == prev_half_carry_ff)
      && (signed_excess_ff == prev_signed_excess_ff) && (zero_ff == prev_zero_ff);
   assign flags_hold_all = flags_hold_zc && (carry_ff == prev_carry_ff);

   property p_zero_only(alu_op_t op);
      op_valid_i && op_i == op |=> (carry_ff == $past(carry_ff))
         && (half_carry_ff == $past(half_carry_ff))
         && (signed_excess_ff == $past(signed_excess_ff))
         && (zero_ff == (acc_ff == '0)) && !mem_we_o && !io_we_o;
   endproperty

   a_lrs_acc: assert property (op_valid_i && op_i == OP_LRS_ACC |=>
      acc_o == {1'b0, $past(acc_ff[DATA_W-1:1])} && carry_ff == $past(acc_ff[0]) && flags_hold_zc)
      else $error("acc right shift result or flags wrong");
   a_rrc_acc: assert property (op_valid_i && op_i == OP_RRC_ACC |=>
      acc_o == {$past(carry_ff), $past(acc_ff[DATA_W-1:1])} && carry_ff == $past(acc_ff[0])
      && flags_hold_zc)
      else $error("acc rotate right result or flags wrong");
   a_right_mem: assert property (op_valid_i && (op_i == OP_LRS_MEM || op_i == OP_RRC_MEM) |=>
      mem_we_o && mem_wdata_o[DATA_W-2:0] == $past(mem_rdata_i[DATA_W-1:1])
      && mem_wdata_o[DATA_W-1] == ($past(op_i == OP_RRC_MEM) && $past(carry_ff))
      && carry_ff == $past(mem_rdata_i[0]) && acc_o == $past(acc_ff) && flags_hold_zc)
      else $error("memory right shift wrong");
   a_lls_acc: assert property (op_valid_i && op_i == OP_LLS_ACC |=>
      acc_o == {$past(acc_ff[DATA_W-2:0]), 1'b0} && carry_ff == $past(acc_ff[DATA_W-1])
      && flags_hold_zc)
      else $error("acc left shift result or flags wrong");
   a_rlc_acc: assert property (op_valid_i && op_i == OP_RLC_ACC |=>
      acc_o == {$past(acc_ff[DATA_W-2:0]), $past(carry_ff)} && carry_ff == $past(acc_ff[DATA_W-1])
      && flags_hold_zc)
      else $error("acc rotate left result or flags wrong");
   a_left_mem: assert property (op_valid_i && (op_i == OP_LLS_MEM || op_i == OP_RLC_MEM) |=>
      mem_we_o && mem_wdata_o[DATA_W-1:1] == $past(mem_rdata_i[DATA_W-2:0])
      && mem_wdata_o[0] == ($past(op_i == OP_RLC_MEM) && $past(carry_ff))
      && carry_ff == $past(mem_rdata_i[DATA_W-1]) && acc_o == $past(acc_ff) && flags_hold_zc)
      else $error("memory left shift or rotate wrong");
   a_swap_acc: assert property (op_valid_i && op_i == OP_SWAP_ACC |=>
      acc_o == {$past(acc_ff[3:0]), $past(acc_ff[DATA_W-1:4])} && flags_hold_all)
      else $error("nibble swap wrong or flags moved");
   a_and_imm: assert property (op_valid_i && op_i == OP_AND_ACC_IMM |=>
      acc_o == ($past(acc_ff) & $past(imm_i)))
      else $error("and immediate result wrong");
   a_and_imm_fl: assert property (p_zero_only(OP_AND_ACC_IMM))
      else $error("and immediate flags wrong");
   a_and_mem: assert property (op_valid_i && op_i == OP_AND_MEM_ACC |=>
      mem_we_o && mem_wdata_o == ($past(acc_ff) & $past(mem_rdata_i)) && acc_o == $past(acc_ff)
      && zero_ff == (mem_wdata_o == '0) && carry_ff == $past(carry_ff))
      else $error("and into memory wrong");
   a_or_imm: assert property (op_valid_i && op_i == OP_OR_ACC_IMM |=>
      acc_o == ($past(acc_ff) | $past(imm_i)) && carry_ff == $past(carry_ff))
      else $error("or immediate wrong");
   a_or_acc_mem: assert property (p_zero_only(OP_OR_ACC_MEM))
      else $error("or memory into acc flags wrong");
   a_xor_mem: assert property (op_valid_i && op_i == OP_XOR_MEM_ACC |=>
      mem_we_o && mem_wdata_o == ($past(acc_ff) ^ $past(mem_rdata_i)) && zero_ff == (mem_wdata_o == '0)
      ##1 (!mem_we_o || $past(op_valid_i)))
      else $error("xor into memory wrong or strobe not one cycle");
   a_xor_io: assert property (op_valid_i && op_i == OP_XOR_IO_ACC |=>
      io_we_o && io_wdata_o == ($past(acc_ff) ^ $past(io_rdata_i)) && flags_hold_all
      && acc_o == $past(acc_ff) && !mem_we_o)
      else $error("xor into io register wrong");
   a_not_acc: assert property (op_valid_i && op_i == OP_NOT_ACC |=>
      acc_o == ~$past(acc_ff) && zero_ff == (acc_o == '0) && carry_ff == $past(carry_ff)
      && half_carry_ff == $past(half_carry_ff) && signed_excess_ff == $past(signed_excess_ff))
      else $error("acc invert wrong");
   a_not_mem: assert property (op_valid_i && op_i == OP_NOT_MEM |=>
      mem_we_o && mem_wdata_o == ~$past(mem_rdata_i) && zero_ff == ($past(mem_rdata_i) == 8'hff))
      else $error("memory invert wrong");
   a_neg_acc: assert property (op_valid_i && op_i == OP_NEG_ACC |=>
      (acc_o + $past(acc_ff)) == 8'h00 && zero_ff == (acc_o == '0)
      && signed_excess_ff == $past(signed_excess_ff))
      else $error("acc negate wrong");
   a_zero_flag: assert property (op_valid_i && op_i == OP_XOR_ACC_IMM && imm_i == acc_ff |=>
      zero_ff && acc_o == 8'h00)
      else $error("zero flag not set on zero result");
   a_or_mem: assert property (op_valid_i && op_i == OP_OR_MEM_ACC |=>
      mem_we_o && mem_wdata_o == ($past(acc_ff) | $past(mem_rdata_i)) && acc_o == $past(acc_ff)
      && zero_ff == (mem_wdata_o == '0) && carry_ff == $past(carry_ff))
      else $error("or into memory wrong");
   a_done_pulse: assert property (op_valid_i |=> done_o)
      else $error("done missing after accepted op");
   a_idle_quiet: assert property (!op_valid_i |=> !done_o && !mem_we_o && !io_we_o && acc_o == $past(acc_ff))
      else $error("outputs moved without an op");
   a_flag_write: assert property (!op_valid_i && flag_we_i |=>
      {signed_excess_ff, half_carry_ff, carry_ff, zero_ff} == $past(flag_wdata_i))
      else $error("direct flag write not applied");
   a_op_beats_flag: assert property (op_valid_i && flag_we_i && op_i == OP_NOP |=> flags_hold_all)
      else $error("flag write not dropped during op");

   c_carry_out: cover property (op_valid_i && op_i == OP_RLC_ACC && acc_ff[DATA_W-1] ##1 carry_ff);
   c_mem_write: cover property (op_valid_i && op_i == OP_NOT_MEM ##1 mem_we_o);
   c_io_write: cover property (op_valid_i && op_i == OP_XOR_IO_ACC ##1 io_we_o);
   c_back_to_back: cover property (op_valid_i ##1 op_valid_i ##1 done_o);
   c_flag_clash: cover property (op_valid_i && flag_we_i ##1 done_o);

endmodule

// >>> test/testbench.sv
`include "alu_params.svh"

module testbench
   import alu_ops_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic op_valid_i = 1'b0;
   alu_op_t op_i = OP_NOP;
   logic [7:0] imm_i = 8'h00;
   logic [7:0] mem_rdata_i = 8'h00;
   logic [7:0] io_rdata_i = 8'h00;
   logic flag_we_i = 1'b0;
   logic [`FLAG_W-1:0] flag_wdata_i = 4'h0;
   logic [7:0] acc_o;
   logic zero_flag_o;
   logic carry_flag_o;
   logic half_carry_flag_o;
   logic signed_excess_flag_o;
   logic mem_we_o;
   logic [7:0] mem_wdata_o;
   logic io_we_o;
   logic [7:0] io_wdata_o;
   logic done_o;
   logic [3:0] flags_w;
   int n_mismatch = 0;
   int compares = 0;

   // same bit order as flag_wdata_i, so presets and expectations read alike
   assign flags_w = {signed_excess_flag_o, half_carry_flag_o, carry_flag_o, zero_flag_o};

   always #5 ref_clk_i = ~ref_clk_i;

   shift_logic_alu_ops #(.DATA_W(8)) u_shift_logic_alu_ops (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .op_valid_i(op_valid_i),
      .op_i(op_i),
      .imm_i(imm_i),
      .mem_rdata_i(mem_rdata_i),
      .io_rdata_i(io_rdata_i),
      .flag_we_i(flag_we_i),
      .flag_wdata_i(flag_wdata_i),
      .acc_o(acc_o),
      .zero_flag_o(zero_flag_o),
      .carry_flag_o(carry_flag_o),
      .half_carry_flag_o(half_carry_flag_o),
      .signed_excess_flag_o(signed_excess_flag_o),
      .mem_we_o(mem_we_o),
      .mem_wdata_o(mem_wdata_o),
      .io_we_o(io_we_o),
      .io_wdata_o(io_wdata_o),
      .done_o(done_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one idle edge before each request, so op_valid_i never toggles twice in a step
   task automatic op(input alu_op_t o, input logic [7:0] b);
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1'b1;
      op_i = o;
      imm_i = b;
      mem_rdata_i = b;
      io_rdata_i = b;
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1'b0;
      chk1(done_o, 1'b1, "done");
   endtask

   task automatic preset(input logic [7:0] a, input logic [3:0] f);
      op(OP_LOAD_ACC_IMM, a);
      @(posedge ref_clk_i);
      #1;
      flag_we_i = 1'b1;
      flag_wdata_i = f;
      @(posedge ref_clk_i);
      #1;
      flag_we_i = 1'b0;
      chk4(flags_w, f, "preset");
   endtask

   task automatic expect_st(input logic [7:0] acc, input logic [3:0] fl, input logic mwe,
                            input logic [7:0] mdat, input logic iwe, input logic [7:0] idat);
      chk8(acc_o, acc, "acc");
      chk4(flags_w, fl, "flags");
      chk1(mem_we_o, mwe, "mem_we");
      chk1(io_we_o, iwe, "io_we");
      if (mwe) begin
         chk8(mem_wdata_o, mdat, "mem_wdata");
      end
      if (iwe) begin
         chk8(io_wdata_o, idat, "io_wdata");
      end
   endtask

   function automatic logic [7:0] lres(input alu_op_t o, input logic [7:0] a, input logic [7:0] b);
      case (o)
         OP_AND_ACC_IMM, OP_AND_ACC_MEM, OP_AND_MEM_ACC: return a & b;
         OP_OR_ACC_IMM, OP_OR_ACC_MEM, OP_OR_MEM_ACC: return a | b;
         OP_XOR_ACC_IMM, OP_XOR_ACC_MEM, OP_XOR_MEM_ACC: return a ^ b;
         OP_NOT_ACC: return ~a;
         OP_NOT_MEM: return ~b;
         OP_NEG_ACC: return 8'h00 - a;
         default: return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_right();
      preset(8'h81, 4'hd);
      op(OP_LRS_ACC, 8'h00);
      expect_st(8'h40, 4'hf, 1'b0, 8'h00, 1'b0, 8'h00);
      op(OP_RRC_ACC, 8'h00);
      expect_st(8'ha0, 4'hd, 1'b0, 8'h00, 1'b0, 8'h00);
      // zero result must not touch the zero flag
      preset(8'h01, 4'h0);
      op(OP_RRC_ACC, 8'h00);
      expect_st(8'h00, 4'h2, 1'b0, 8'h00, 1'b0, 8'h00);
      preset(8'h33, 4'h8);
      op(OP_LRS_MEM, 8'h03);
      expect_st(8'h33, 4'ha, 1'b1, 8'h01, 1'b0, 8'h00);
      op(OP_RRC_MEM, 8'h02);
      expect_st(8'h33, 4'h8, 1'b1, 8'h81, 1'b0, 8'h00);
   endtask

   task automatic t_left();
      preset(8'h81, 4'hd);
      op(OP_LLS_ACC, 8'h00);
      expect_st(8'h02, 4'hf, 1'b0, 8'h00, 1'b0, 8'h00);
      op(OP_RLC_ACC, 8'h00);
      expect_st(8'h05, 4'hd, 1'b0, 8'h00, 1'b0, 8'h00);
      preset(8'h33, 4'h4);
      op(OP_LLS_MEM, 8'h80);
      expect_st(8'h33, 4'h6, 1'b1, 8'h00, 1'b0, 8'h00);
      op(OP_RLC_MEM, 8'h40);
      expect_st(8'h33, 4'h4, 1'b1, 8'h81, 1'b0, 8'h00);
   endtask

   task automatic t_swap();
      preset(8'h3c, 4'hf);
      op(OP_SWAP_ACC, 8'h00);
      expect_st(8'hc3, 4'hf, 1'b0, 8'h00, 1'b0, 8'h00);
      preset(8'h1e, 4'h0);
      op(OP_SWAP_ACC, 8'h00);
      expect_st(8'he1, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
   endtask

   task automatic t_xor_io();
      preset(8'h5a, 4'ha);
      op(OP_XOR_IO_ACC, 8'h0f);
      expect_st(8'h5a, 4'ha, 1'b0, 8'h00, 1'b1, 8'h55);
      op(OP_XOR_IO_ACC, 8'h5a);
      expect_st(8'h5a, 4'ha, 1'b0, 8'h00, 1'b1, 8'h00);
   endtask

   // second op issued on the very next edge must see the first op's carry
   task automatic t_back2back();
      preset(8'h81, 4'h0);
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1'b1;
      op_i = OP_LLS_ACC;
      @(posedge ref_clk_i);
      #1;
      op_i = OP_RRC_ACC;
      expect_st(8'h02, 4'h2, 1'b0, 8'h00, 1'b0, 8'h00);
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1'b0;
      expect_st(8'h81, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
   endtask

   // op and flag write in one cycle: the op wins, done stands one cycle
   task automatic t_nop_flag();
      preset(8'h81, 4'h0);
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1'b1;
      op_i = OP_NOP;
      flag_we_i = 1'b1;
      flag_wdata_i = 4'hf;
      @(posedge ref_clk_i);
      #1;
      op_valid_i = 1'b0;
      flag_we_i = 1'b0;
      chk1(done_o, 1'b1, "nop_done");
      expect_st(8'h81, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
      @(posedge ref_clk_i);
      #1;
      chk1(done_o, 1'b0, "done_pulse");
      expect_st(8'h81, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
   endtask

   // reset in mid-run must clear every register again
   task automatic t_reset();
      preset(8'hc3, 4'hf);
      @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b0;
      @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
      expect_st(8'h00, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
      chk1(done_o, 1'b0, "done_rst2");
      chk8(mem_wdata_o, 8'h00, "mem_wdata_rst");
      chk8(io_wdata_o, 8'h00, "io_wdata_rst");
   endtask

   localparam int N_LOGIC = 19;
   alu_op_t l_op[N_LOGIC] = '{OP_AND_ACC_IMM, OP_AND_ACC_IMM, OP_AND_ACC_MEM, OP_AND_MEM_ACC, OP_AND_MEM_ACC,
      OP_OR_ACC_IMM, OP_OR_ACC_IMM, OP_OR_ACC_MEM, OP_OR_MEM_ACC, OP_XOR_ACC_IMM, OP_XOR_ACC_MEM,
      OP_XOR_MEM_ACC, OP_NOT_ACC, OP_NOT_ACC, OP_NOT_MEM, OP_NOT_MEM, OP_NEG_ACC, OP_NEG_ACC, OP_NEG_ACC};
   logic [7:0] l_acc[N_LOGIC] = '{8'h5a, 8'h0f, 8'h5a, 8'h5a, 8'h5a, 8'h00, 8'h5a, 8'h5a, 8'h00, 8'h5a,
      8'h5a, 8'h5a, 8'h38, 8'hff, 8'h5a, 8'h5a, 8'h38, 8'h00, 8'h80};
   logic [7:0] l_opnd[N_LOGIC] = '{8'ha5, 8'h3c, 8'hff, 8'h0f, 8'ha5, 8'h00, 8'h81, 8'ha5, 8'h00, 8'h5a,
      8'ha5, 8'h0f, 8'h00, 8'h00, 8'hff, 8'h38, 8'h00, 8'h00, 8'h00};

   // zero flag preset opposite to the expected one; other flags alternate to catch stray writes
   task automatic t_logic();
      logic [7:0] r;
      logic [3:0] pre;
      logic m;
      logic [7:0] ea;
      logic [3:0] ef;
      for (int i = 0; i < N_LOGIC; i++) begin
         r = lres(l_op[i], l_acc[i], l_opnd[i]);
         pre = {{3{i[0]}}, r != 8'h00};
         m = (l_op[i] inside {OP_AND_MEM_ACC, OP_OR_MEM_ACC, OP_XOR_MEM_ACC, OP_NOT_MEM});
         preset(l_acc[i], pre);
         op(l_op[i], l_opnd[i]);
         ea = m ? l_acc[i] : r;
         ef = {pre[3:1], r == 8'h00};
         expect_st(ea, ef, m, r, 1'b0, 8'h00);
         chk1(zero_flag_o, r == 8'h00, "zero");
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      // whole run is a few hundred cycles; this leaves a wide margin
      #200000;
      n_mismatch++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
      expect_st(8'h00, 4'h0, 1'b0, 8'h00, 1'b0, 8'h00);
      chk1(done_o, 1'b0, "done_rst");
      t_right();
      t_left();
      t_swap();
      t_xor_io();
      t_back2back();
      t_logic();
      t_nop_flag();
      t_reset();
      wrap_up();
   end
endmodule
